// ===== hdl/cfp_consts.vh
// Constants for the configuration controller power-on reset and restart block
// Notes on behaviour
// - Three-bit page select picks one of eight images
// - Top select bit is MSB; default page zero
// - Optional external clock drives configuration clock
// - Delay select low 100 ms, high 2 ms
// - Hold reset until supply stable and delay expired
// - Shared enable held low extends reset
// - Reset at power-up and on supply dropout
// - FPGA status low forces reset
// - Missing done after all data restarts
// - Flash accessed sixteen bits wide, word mode
// - Done high at enable rise means idle
// - Idle left only by power cycle
`ifndef CFP_CONSTS_VH
`define CFP_CONSTS_VH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CFP_CLK_HZ        20000000
`define CFP_LONG_MS       100
`define CFP_SHORT_MS      2
`define CFP_LONG_CYC      ((`CFP_CLK_HZ / 1000) * `CFP_LONG_MS)
`define CFP_SHORT_CYC     ((`CFP_CLK_HZ / 1000) * `CFP_SHORT_MS)
`define CFP_CNT_W         22

// ----------------------------------------------------------------------
// Fields and levels
// ----------------------------------------------------------------------
`define CFP_PAGE_W        3
`define CFP_PAGE_DEF      3'h0
`define CFP_WORD_MODE     1'b1
`define CFP_DONE_WAIT     16'h0010

// ----------------------------------------------------------------------
// States
// ----------------------------------------------------------------------
`define CFP_ST_POR        3'h0
`define CFP_ST_REL        3'h1
`define CFP_ST_CFG        3'h2
`define CFP_ST_CHK        3'h3
`define CFP_ST_RUN        3'h4
`define CFP_ST_IDLE       3'h5
`define CFP_ST_RST        3'h6

`endif

// ===== hdl/cfp_sync.v
// Two flip-flop synchroniser for one level from outside the clock domain
module cfp_sync #(
    parameter RST_VAL = 1'b0
) (
    input  wire mclk,
    input  wire rst_b,
    input  wire din,
    output wire dout
);
    reg s1_q;  // First stage, read only by second stage
    reg s2_q;  // Stable stage

    // ----------------------------------------------------------------------
    // Chain
    // ----------------------------------------------------------------------
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
        end
    end
    assign dout = s2_q;
endmodule

// ===== hdl/cfp_delay.v
// Power-on delay counter with two selectable terminal counts
`include "cfp_consts.vh"
module cfp_delay #(
    parameter LONG_CYC  = `CFP_LONG_CYC,
    parameter SHORT_CYC = `CFP_SHORT_CYC
) (
    input  wire mclk,
    input  wire rst_b,
    input  wire run,
    input  wire short_sel,
    output wire expired
);
    // Terminal values worked out at full width, then cut to the counter
    localparam [31:0]           LONG_M1  = LONG_CYC - 1;
    localparam [31:0]           SHORT_M1 = SHORT_CYC - 1;
    localparam [`CFP_CNT_W-1:0] LONG_T   = LONG_M1[`CFP_CNT_W-1:0];
    localparam [`CFP_CNT_W-1:0] SHORT_T  = SHORT_M1[`CFP_CNT_W-1:0];

    reg  [`CFP_CNT_W-1:0] cnt_q;   // Cycles counted so far
    reg                   exp_q;   // Terminal reached
    wire [`CFP_CNT_W-1:0] term;    // Selected terminal count

    assign term = short_sel ? SHORT_T : LONG_T;

    // ----------------------------------------------------------------------
    // Count while run; restart from zero when run drops
    // ----------------------------------------------------------------------
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= {`CFP_CNT_W{1'b0}};
            exp_q <= 1'b0;
        end else if (!run) begin
            cnt_q <= {`CFP_CNT_W{1'b0}};
            exp_q <= 1'b0;
        end else if (cnt_q >= term) begin
            exp_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + {{(`CFP_CNT_W-1){1'b0}}, 1'b1};
        end
    end
    assign expired = exp_q;
endmodule

// ===== hdl/cfp_por_ctrl.v
// Power-on reset and restart controller top level
`include "cfp_consts.vh"
module cfp_por_ctrl #(
    parameter LONG_CYC  = `CFP_LONG_CYC,
    parameter SHORT_CYC = `CFP_SHORT_CYC,
    parameter CLK_DIV   = 2
) (
    input  wire                   mclk,
    input  wire                   rst_b,
    input  wire                   supply_good,
    input  wire                   reset_delay_select,
    input  wire [`CFP_PAGE_W-1:0] image_page_select,
    input  wire                   use_external_clock,
    input  wire                   external_clock_input,
    input  wire                   oe_in,
    output wire                   oe_out,
    output wire                   oe_oe_b,
    input  wire                   fpga_status_low,
    input  wire                   configuration_complete,
    input  wire                   data_done,
    input  wire                   serial_data_in,
    output reg                    serial_data_out,
    output reg                    configuration_clock_output,
    output reg  [`CFP_PAGE_W-1:0] active_page,
    output reg                    cfg_active,
    output reg                    por_complete,
    output reg                    cfg_error,
    output reg                    idle_locked,
    output wire                   flash_word_mode
);
    // ----------------------------------------------------------------------
    // Synchronised pins
    // ----------------------------------------------------------------------
    wire sup_s;     // Supply good
    wire sel_s;     // Delay select
    wire oe_s;      // Shared enable line level
    wire sts_s;     // FPGA status, active low
    wire done_s;    // Configuration complete
    wire ext_s;     // External clock level
    wire [`CFP_PAGE_W-1:0] page_s;
    wire dlast_s;   // Last data word sent marker

    // Every pin passes two flops before the sequencer reads it
    // Reset level 0: the shared line is pulled low then, so no false rise
    // Supply monitor level
    cfp_sync #(.RST_VAL(1'b0)) u_sup (
        .mclk  (mclk),
        .rst_b (rst_b),
        .din   (supply_good),
        .dout  (sup_s)
    );
    // Delay select level
    cfp_sync #(.RST_VAL(1'b0)) u_sel (
        .mclk  (mclk),
        .rst_b (rst_b),
        .din   (reset_delay_select),
        .dout  (sel_s)
    );
    // Shared line level as seen on the board
    cfp_sync #(.RST_VAL(1'b0)) u_oe (
        .mclk  (mclk),
        .rst_b (rst_b),
        .din   (oe_in),
        .dout  (oe_s)
    );
    // FPGA status asserted
    cfp_sync #(.RST_VAL(1'b0)) u_sts (
        .mclk  (mclk),
        .rst_b (rst_b),
        .din   (fpga_status_low),
        .dout  (sts_s)
    );
    // Configuration done level
    cfp_sync #(.RST_VAL(1'b0)) u_done (
        .mclk  (mclk),
        .rst_b (rst_b),
        .din   (configuration_complete),
        .dout  (done_s)
    );
    // External clock; its edges are found after the second flop
    cfp_sync #(.RST_VAL(1'b0)) u_ext (
        .mclk  (mclk),
        .rst_b (rst_b),
        .din   (external_clock_input),
        .dout  (ext_s)
    );
    // Last-word marker from the data source
    cfp_sync #(.RST_VAL(1'b0)) u_dl (
        .mclk  (mclk),
        .rst_b (rst_b),
        .din   (data_done),
        .dout  (dlast_s)
    );

    // Page bits may settle a cycle apart; the wait state re-latches each cycle
    genvar gi;
    generate
        for (gi = 0; gi < `CFP_PAGE_W; gi = gi + 1) begin : g_pg
            cfp_sync #(.RST_VAL(1'b0)) u_pg (
                .mclk  (mclk),
                .rst_b (rst_b),
                .din   (image_page_select[gi]),
                .dout  (page_s[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------------
    // State
    // ----------------------------------------------------------------------
    reg  [2:0]  st_q;      // Sequencer state
    reg  [2:0]  st_d;
    reg         hold_q;    // We drive the shared line low
    reg         hold_d;
    reg         sup_ok_q;  // Supply level last cycle, for dropout detect
    reg         oe_prev_q; // Line level last cycle, for rise detect
    reg  [15:0] wait_q;    // Done wait after last data
    reg  [7:0]  div_q;     // Internal clock divider
    reg         ext_prev_q;
    reg         cfg_tick;  // One configuration clock edge this cycle
    wire        dly_exp;   // Delay counter expired
    wire        oe_rise;   // Shared line rising
    wire        in_por;    // Counting phase

    // Decodes shared by several processes
    assign in_por  = (st_q == `CFP_ST_POR);
    assign oe_rise = oe_s & ~oe_prev_q;

    // Counter only runs once supply is stable: ramp time adds to delay
    // Delay select reaches the counter only through its synchroniser
    cfp_delay #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC)) u_dly (
        .mclk(mclk),
        .rst_b(rst_b),
        .run(in_por & sup_s),
        .short_sel(sel_s),
        .expired(dly_exp)
    );

    // Open-drain line: enable low means we pull it low
    assign oe_out  = 1'b0;
    assign oe_oe_b = ~hold_q;
    // Word mode is fixed: the flash is always read sixteen bits wide
    assign flash_word_mode = `CFP_WORD_MODE;

    // ----------------------------------------------------------------------
    // Sequencer next state
    // ----------------------------------------------------------------------
    // Counting phase first, then a wait for the line to rise. Done high
    // at the rise means the FPGA is absent or already loaded: fall idle
    // for good. Otherwise send data; after the last word the done level
    // is watched for a short window and a miss pulls the line one cycle.
    // Status low overrides every state but idle and the counting phase,
    // so an FPGA that is still powering up cannot shorten the delay.
    // A supply dropout overrides everything, idle included, since it is
    // the power cycle that idle waits for.
    always @* begin
        // Stay put unless a branch below moves on
        st_d   = st_q;
        hold_d = hold_q;
        case (st_q)
            `CFP_ST_POR: begin
                // Pull the line low until the counter expires
                hold_d = 1'b1;
                if (dly_exp) begin
                    st_d   = `CFP_ST_REL;
                    hold_d = 1'b0;
                end
            end
            `CFP_ST_REL: begin
                // External holder keeps us waiting while line is low
                if (oe_rise) begin
                    if (done_s)
                        st_d = `CFP_ST_IDLE;
                    else
                        st_d = `CFP_ST_CFG;
                end
            end
            `CFP_ST_CFG: begin
                // Line pulled by the board or FPGA: abandon the frame
                if (!oe_s)
                    st_d = `CFP_ST_REL;
                else if (dlast_s)
                    st_d = `CFP_ST_CHK;
            end
            `CFP_ST_CHK: begin
                // Done seen in the window: FPGA is in user mode
                if (done_s)
                    st_d = `CFP_ST_RUN;
                else if (wait_q == `CFP_DONE_WAIT) begin
                    st_d   = `CFP_ST_RST;
                    hold_d = 1'b1;
                end
            end
            `CFP_ST_RUN: begin
                // User mode lasts until the line drops again
                if (!oe_s)
                    st_d = `CFP_ST_REL;
            end
            `CFP_ST_IDLE: begin
                st_d = `CFP_ST_IDLE;
            end
            `CFP_ST_RST: begin
                // One cycle pull, then release and wait for the line
                hold_d = 1'b0;
                st_d   = `CFP_ST_REL;
            end
            default: begin
                st_d   = `CFP_ST_POR;
                hold_d = 1'b1;
            end
        endcase
        // FPGA status low: back to released wait, no data out
        if (sts_s && st_q != `CFP_ST_IDLE && st_q != `CFP_ST_POR) begin
            st_d   = `CFP_ST_REL;
            hold_d = 1'b0;
        end
        // Supply dropout after stable restarts power-on reset
        if (sup_ok_q && !sup_s) begin
            st_d   = `CFP_ST_POR;
            hold_d = 1'b1;
        end
    end

    // ----------------------------------------------------------------------
    // Sequencer registers
    // ----------------------------------------------------------------------
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_q       <= `CFP_ST_POR;
            hold_q     <= 1'b1;
            sup_ok_q   <= 1'b0;
            oe_prev_q  <= 1'b0;
            wait_q     <= 16'h0000;
        end else begin
            st_q      <= st_d;
            hold_q    <= hold_d;
            oe_prev_q <= oe_s;
            // Last supply level, so a dropout is seen as an edge
            if (sup_s)
                sup_ok_q <= 1'b1;
            else
                sup_ok_q <= 1'b0;
            // Done window counts only while checking
            if (st_q == `CFP_ST_CHK)
                wait_q <= wait_q + 16'h0001;
            else
                wait_q <= 16'h0000;
        end
    end

    // ----------------------------------------------------------------------
    // Configuration clock source: internal divider or external edges
    // ----------------------------------------------------------------------
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            div_q      <= 8'h00;
            ext_prev_q <= 1'b0;
            cfg_tick   <= 1'b0;
        end else begin
            ext_prev_q <= ext_s;
            // Divider and tick run free; the outputs use the tick only in the configuring state
            if (div_q >= CLK_DIV[7:0] - 8'h01)
                div_q <= 8'h00;
            else
                div_q <= div_q + 8'h01;
            // Switching source mid-frame may give one short clock phase
            if (use_external_clock)
                cfg_tick <= ext_s ^ ext_prev_q;
            else
                cfg_tick <= (div_q >= CLK_DIV[7:0] - 8'h01);
        end
    end

    // ----------------------------------------------------------------------
    // Outputs; clock and data toggle only while configuring
    // ----------------------------------------------------------------------
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            configuration_clock_output <= 1'b0;
            serial_data_out            <= 1'b0;
            active_page                <= `CFP_PAGE_DEF;
            cfg_active                 <= 1'b0;
            por_complete               <= 1'b0;
            cfg_error                  <= 1'b0;
            idle_locked                <= 1'b0;
        end else begin
            // Status outputs lag the state by one cycle
            cfg_active   <= (st_q == `CFP_ST_CFG);
            por_complete <= ~in_por;
            idle_locked  <= (st_q == `CFP_ST_IDLE);
            // Sticky, so a host can see that an attempt failed
            if (st_q == `CFP_ST_RST)
                cfg_error <= 1'b1;
            else if (st_q == `CFP_ST_RUN || in_por)
                cfg_error <= 1'b0;
            // Page follows the pins only while waiting for the line
            if (st_q == `CFP_ST_REL)
                active_page <= page_s;
            // Data changes as the clock falls, so it is steady at the rise
            if (st_q == `CFP_ST_CFG && cfg_tick) begin
                configuration_clock_output <= ~configuration_clock_output;
                if (configuration_clock_output)
                    serial_data_out <= serial_data_in;
            end else if (st_q != `CFP_ST_CFG) begin
                configuration_clock_output <= 1'b0;
                serial_data_out            <= 1'b0;
            end
        end
    end
endmodule

// ===== verification/cfp_checker.sv
// Port-level assertions for the power-on reset and restart block
`include "cfp_consts.vh"
module cfp_checker #(
    parameter LONG_CYC  = 50,
    parameter SHORT_CYC = 20
) (
    input wire                   mclk,
    input wire                   rst_b,
    input wire                   supply_good,
    input wire                   reset_delay_select,
    input wire                   oe_in,
    input wire                   oe_oe_b,
    input wire                   oe_out,
    input wire                   fpga_status_low,
    input wire                   configuration_clock_output,
    input wire [`CFP_PAGE_W-1:0] active_page,
    input wire                   cfg_active,
    input wire                   cfg_error,
    input wire                   idle_locked,
    input wire                   flash_word_mode
);
    integer good_q; // Unbroken good-supply cycles

    // Count good supply; a dip restarts it, as a real monitor would
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            good_q <= 0;
        else if (!supply_good)
            good_q <= 0;
        else if (good_q < 32'h7fffffff)
            good_q <= good_q + 1;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence s_err; $rose(cfg_error); endsequence
    sequence s_pull; $past(oe_oe_b) == 1'b0; endsequence

    property p_word; flash_word_mode == 1'b1 && oe_out == 1'b0; endproperty
    property p_short; $rose(oe_oe_b) |-> good_q >= SHORT_CYC; endproperty
    property p_long; $rose(oe_oe_b) && !reset_delay_select |-> good_q >= LONG_CYC; endproperty
    property p_drop; (!supply_good && !idle_locked) [*5] |-> !oe_oe_b; endproperty
    property p_hold; (!oe_in) [*6] |-> !cfg_active; endproperty
    property p_stat; fpga_status_low [*6] |-> !cfg_active; endproperty
    property p_idle; idle_locked |-> !cfg_active && !configuration_clock_output; endproperty
    property p_lock; idle_locked |=> idle_locked; endproperty
    property p_page; cfg_active |-> $stable(active_page); endproperty
    property p_err; s_err |-> s_pull; endproperty

    a_word: assert property (p_word) else $error("flash width or pin drive wrong");
    a_short: assert property (p_short) else $error("line freed too early");
    a_long: assert property (p_long) else $error("long delay cut short");
    a_drop: assert property (p_drop) else $error("supply drop kept line free");
    a_hold: assert property (p_hold) else $error("configured while line held");
    a_stat: assert property (p_stat) else $error("status ignored");
    a_idle: assert property (p_idle) else $error("idle not quiet");
    a_lock: assert property (p_lock) else $error("idle left");
    a_page: assert property (p_page) else $error("page moved in config");
    a_err: assert property (p_err) else $error("error without restart");
endmodule

// ===== verification/cfp_fpga_model.sv
// Behavioural FPGA and pulled-up shared enable line
module cfp_fpga_model #(
    parameter DATA_EDGES = 16
) (
    input  wire       mclk,
    input  wire       oe_oe_b,
    input  wire       cfg_clk,
    input  wire       hold_low,
    input  wire [1:0] mode,
    output wire       oe_in,
    output wire       done,
    output wire       data_done
);
    timeunit 1ns;
    timeprecision 1ns;
    integer edges = 0;    // Clock rises since line rose
    logic   clk_q = 1'b0; // Last clock level

    // Pull-up: low while either party pulls it
    assign oe_in = !(!oe_oe_b || hold_low);
    // All data taken once enough rises pass
    assign data_done = oe_in && edges >= DATA_EDGES;
    // Mode 2: unpowered FPGA, done pulled high; mode 1: done follows data
    assign done = mode == 2'h2 || (mode == 2'h1 && data_done);
    // No scan traffic is ever offered by this board model

    // Count rises; a low line restarts the frame
    always @(posedge mclk) begin
        clk_q <= cfg_clk;
        if (!oe_in)
            edges <= 0;
        else if (cfg_clk && !clk_q)
            edges <= edges + 1;
    end
endmodule

// ===== verification/config_controller_por_restart_test.sv
// Self-checking bench for the power-on reset and restart block
`include "cfp_consts.vh"
module config_controller_por_restart_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam LONG = 50;     // Shortened long delay
    localparam SHORT = 20;    // Shortened short delay
    logic       mclk = 1'b0;  // System clock
    logic       rst_b = 1'b0; // Power-up reset
    logic       sup = 1'b0;   // Supply monitor
    logic       dsel = 1'b1;  // Delay select
    logic [2:0] page = 3'h0;  // Image page
    logic       use_ext = 0;  // External clock on
    logic       ext_clk = 0;  // External clock
    logic       status = 0;   // FPGA status asserted
    logic       sdi = 0;      // Serial data source
    logic       hold = 0;     // Board holds line low
    logic [1:0] mode = 2'h1;  // FPGA behaviour
    logic [2:0] pg_exp = 3'h0; // Page the image should use
    wire        oe_in, oe_out, oe_oe_b, done, ddone, sdo, cclk, word;
    wire        cfg_active, por_complete, cfg_error, idle_locked;
    wire  [2:0] act_page;
    integer     fail_count = 0, tests_run = 0, n, t;

    cfp_por_ctrl #(.LONG_CYC(LONG), .SHORT_CYC(SHORT), .CLK_DIV(2)) i_dut (
        .mclk(mclk), .rst_b(rst_b), .supply_good(sup), .reset_delay_select(dsel),
        .image_page_select(page), .use_external_clock(use_ext),
        .external_clock_input(ext_clk), .oe_in(oe_in), .oe_out(oe_out), .oe_oe_b(oe_oe_b),
        .fpga_status_low(status), .configuration_complete(done), .data_done(ddone),
        .serial_data_in(sdi), .serial_data_out(sdo), .configuration_clock_output(cclk),
        .active_page(act_page), .cfg_active(cfg_active), .por_complete(por_complete),
        .cfg_error(cfg_error), .idle_locked(idle_locked), .flash_word_mode(word));
    cfp_fpga_model #(.DATA_EDGES(16)) i_fpga (.mclk(mclk), .oe_oe_b(oe_oe_b),
        .cfg_clk(cclk), .hold_low(hold), .mode(mode), .oe_in(oe_in), .done(done),
        .data_done(ddone));

    // Clocks: link clock offset so its phase is unrelated, runs only when chosen
    always #25 mclk = ~mclk;
    initial #7 forever #200 if (use_ext) ext_clk = ~ext_clk;
    always @(negedge mclk) sdi <= $urandom;

    // ----------
    // Helpers
    // ----------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: sig = oe_oe_b;
            1: sig = cfg_active;
            2: sig = cfg_error;
            3: sig = idle_locked;
            default: sig = ddone;
        endcase
    endfunction
    // Bounded wait; t holds cycles taken
    task automatic wait_for(input int s, input logic v);
        t = 0;
        while (sig(s) !== v && t < 600) begin
            @(negedge mclk);
            t++;
        end
        if (t >= 600) check("wait limit", sig(s), v);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask
    task automatic toggles(input int k);
        logic p;
        p = cclk;
        n = 0;
        repeat (k) begin
            @(negedge mclk);
            if (cclk !== p) n++;
            if (p === 1'b1 && cclk === 1'b0) check("data out", sdo, sdi);
            p = cclk;
        end
    endtask
    // Line pulse makes the rise that starts a new frame
    task automatic restart();
        hold = 1;
        cyc(8);
        hold = 0;
        wait_for(1, 1);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Watchdog sized well past the full sequence
    initial begin
        #1000000;
        fail_count++;
        end_sim();
    end

    initial begin
        n = $urandom(66);
        page = $urandom;
        hold = 1;
        cyc(8);
        check("oe in reset", oe_oe_b, 0);
        check("word mode", word, 1);
        check("open drain", oe_out, 0);
        check("page default", act_page, `CFP_PAGE_DEF);
        $display("test reset done");
        rst_b = 1;
        cyc(3);
        sup = 1;
        wait_for(0, 1);
        check("short delay", t >= SHORT && t <= SHORT + 8, 1);
        cyc(20);
        check("held by board", cfg_active, 0);
        check("por done", por_complete, 1);
        hold = 0;
        wait_for(1, 1);
        check("config start", cfg_active, 1);
        check("page", act_page, page);
        toggles(20);
        check("internal clock", n, 20 / 2);
        wait_for(1, 0);
        check("no error", cfg_error, 0);
        $display("test power-up done");
        restart();
        status = 1;
        cyc(8);
        check("status reset", cfg_active, 0);
        status = 0;
        mode = 2'h0;
        restart();
        wait_for(4, 1);
        wait_for(2, 1);
        check("done timeout", t >= 16 && t <= 24, 1);
        mode = 2'h1;
        wait_for(2, 0);
        check("recovered", cfg_error, 0);
        $display("test restart done");
        use_ext = 1;
        page = $urandom;
        pg_exp = page;
        restart();
        check("new page", act_page, pg_exp);
        page = ~pg_exp;
        toggles(40);
        check("external clock", n >= 9 && n <= 11, 1);
        check("page held", act_page, pg_exp);
        wait_for(1, 0);
        use_ext = 0;
        $display("test external clock done");
        sup = 0;
        cyc(6);
        check("drop pulls", oe_oe_b, 0);
        check("drop por", por_complete, 0);
        dsel = 0;
        cyc(2);
        sup = 1;
        wait_for(0, 1);
        check("long delay", t >= LONG && t <= LONG + 8, 1);
        $display("test dropout done");
        rst_b = 0;
        mode = 2'h2;
        cyc(2);
        rst_b = 1;
        wait_for(3, 1);
        check("idle entered", idle_locked, 1);
        toggles(20);
        check("idle quiet", n, 0);
        status = 1;
        hold = 1;
        cyc(8);
        status = 0;
        hold = 0;
        cyc(8);
        check("idle kept", idle_locked, 1);
        $display("test idle done");
        end_sim();
    end
endmodule

bind cfp_por_ctrl cfp_checker #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC)) i_chk (
    .mclk(mclk), .rst_b(rst_b), .supply_good(supply_good),
    .reset_delay_select(reset_delay_select), .oe_in(oe_in), .oe_oe_b(oe_oe_b),
    .oe_out(oe_out), .fpga_status_low(fpga_status_low),
    .configuration_clock_output(configuration_clock_output), .active_page(active_page),
    .cfg_active(cfg_active), .cfg_error(cfg_error), .idle_locked(idle_locked),
    .flash_word_mode(flash_word_mode));
